// ### shared/bus_timing_consts.vh
`ifndef BUS_TIMING_CONSTS_VH
`define BUS_TIMING_CONSTS_VH
// register byte offsets
`define OFS_STALL_COUNT_CONTROL 4'h0
`define OFS_BUS_CONTROL_SECOND 4'h4
`define OFS_STATUS 4'h8
// bus_control_second reset and field positions
`define BCS_RESET 16'hffff
`define BCS_EXT_LSB 0
`define BCS_GAP_LSB 4
`define BCS_IDLE_LSB 8
// stall_count_control reset, reserved read-as-one bits
`define SCC_RESET 16'hffff
`define SCC_FORCED_HI 8'hcc
// wait field base inside stall_count_control
`define SCC_WAIT_LSB 0
// idle count on leaving the gap state
`define IDLE_AFTER_GAP 2'h1
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// state codes
`define ST_IDLE 3'h0
`define ST_LEAD 3'h1
`define ST_FIRST 3'h2
`define ST_STALL 3'h3
`define ST_SECOND 3'h4
`define ST_TRAIL 3'h5
`define ST_GAP 3'h6
`endif

// ### src/ordinary_space_bus_timing.v
// Function
// - a plain access takes exactly two bus clock states
// - reads latch the whole data bus while the read strobe is low
// - writes qualify data bits 7 to 0 with the low-byte write strobe
// - zero to three software wait states per space from its wait field
// - stall input sampled two edges before the last wait moves to second state
// - assert extension adds one lead state and one trail state
// - lead and trail keep space select low, both strobes high
// - write data stays driven through the trail state
// - after a read, turnaround idles before a write or other-space read
// - idle cycles already elapsed count toward the turnaround
// - separate two-bit turnaround count for each of four spaces
// - same-space back-to-back access gets gap idles, select negated once
// - write after read uses the larger of turnaround and gap counts
// - no gap idles when idles already separate same-space accesses
// - wait field zero disables stall sampling; fields reset to three
// - gap bit set means one idle cycle; resets set
// - turnaround field 00..11 gives 0..3 idles; resets to three
// - extension bit set enables lead and trail; resets set
`timescale 1ns/100ps
`default_nettype none
`include "bus_timing_consts.vh"
module ordinary_space_bus_timing #(
   parameter ADDR_W = 16,
   parameter DATA_W = 16
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire req_valid,
   output wire req_ready,
   input wire req_write,
   input wire [1:0] req_space,
   input wire [ADDR_W-1:0] req_addr,
   input wire [7:0] req_wdata,
   output reg done_pulse,
   output reg [DATA_W-1:0] done_rdata,
   output reg [ADDR_W-1:0] mem_addr,
   output reg [3:0] space_select_n,
   output reg read_strobe_n,
   output reg low_byte_write_strobe_n,
   output reg [7:0] mem_dout,
   output reg mem_doe,
   input wire [DATA_W-1:0] mem_din,
   input wire stall_n
);
////////////////////////////////////////////////////////////////////////
// registers and synchronisers
reg [15:0] stall_count_control_reg;
reg [15:0] bus_control_second_reg;
reg [1:0] stall_sync_reg;
// raw data bus, registered every cycle so a two-state read still lands
reg [DATA_W-1:0] din_s1_reg;
reg [2:0] state_reg;
reg [1:0] wait_cnt_reg;
reg [1:0] idle_cnt_reg;
reg [1:0] prev_space_reg;
reg prev_read_reg;
reg prev_valid_reg;
reg cur_write_reg;
reg [1:0] cur_space_reg;
reg [1:0] cur_wait_reg;
reg cur_ext_reg;
reg [31:0] access_count_reg;
reg aw_held_reg;
reg w_held_reg;
reg [3:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
wire stall_low = ~stall_sync_reg[1];

function [1:0] field2;
   input [15:0] r;
   input [1:0] sp;
   input integer lsb;
   begin
      field2 = r[lsb + 4 * sp +: 2];
   end
endfunction

////////////////////////////////////////////////////////////////////////
// per-space single-bit fields
function space_bit;
   input [15:0] r;
   input [1:0] sp;
   input integer lsb;
   begin
      space_bit = r[lsb + sp];
   end
endfunction

function [1:0] idles_needed;
   input [1:0] sp;
   input wr;
   reg [1:0] iw;
   reg [1:0] cw;
   begin
      iw = 2'h0;
      cw = 2'h0;
      if (prev_valid_reg && prev_read_reg && (wr || sp != prev_space_reg))
         iw = bus_control_second_reg[`BCS_IDLE_LSB + 2 * prev_space_reg +: 2];
      if (prev_valid_reg && sp == prev_space_reg)
         cw = {1'b0, space_bit(bus_control_second_reg, sp, `BCS_GAP_LSB)};
      idles_needed = (iw > cw) ? iw : cw;
   end
endfunction

////////////////////////////////////////////////////////////////////////
// register bus
wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
assign s_axi_awready = !aw_held_reg;
assign s_axi_wready = !w_held_reg;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge sys_clk) begin
   if (!rst_n) begin
      stall_count_control_reg <= `SCC_RESET;
      bus_control_second_reg <= `BCS_RESET;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0;
   end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= `RESP_OKAY;
         if (aw_addr_reg == `OFS_STALL_COUNT_CONTROL) begin
            if (w_strb_reg[0])
               stall_count_control_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1])
               // reserved high bits always read as one
               stall_count_control_reg[15:8] <= w_data_reg[15:8] | `SCC_FORCED_HI;
         end else if (aw_addr_reg == `OFS_BUS_CONTROL_SECOND) begin
            if (w_strb_reg[0])
               bus_control_second_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1])
               bus_control_second_reg[15:8] <= w_data_reg[15:8];
         end else if (aw_addr_reg != `OFS_STATUS)
            s_axi_bresp <= `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `OFS_STALL_COUNT_CONTROL: s_axi_rdata <= {16'h0, stall_count_control_reg};
            `OFS_BUS_CONTROL_SECOND: s_axi_rdata <= {16'h0, bus_control_second_reg};
            `OFS_STATUS: s_axi_rdata <= access_count_reg;
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// access sequencer
// idle cycles owed before a new request may start
wire [1:0] need_idles = idles_needed(req_space, req_write);
assign req_ready = (state_reg == `ST_IDLE) && (need_idles <= idle_cnt_reg);

always @(posedge sys_clk) begin
   if (!rst_n) begin
      stall_sync_reg <= 2'b11;
      din_s1_reg <= {DATA_W{1'b0}};
      state_reg <= `ST_IDLE;
      wait_cnt_reg <= 2'h0;
      idle_cnt_reg <= 2'h0;
      prev_space_reg <= 2'h0;
      prev_read_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
      cur_write_reg <= 1'b0;
      cur_space_reg <= 2'h0;
      cur_wait_reg <= 2'h0;
      cur_ext_reg <= 1'b0;
      access_count_reg <= 32'h0;
      done_pulse <= 1'b0;
      done_rdata <= {DATA_W{1'b0}};
      mem_addr <= {ADDR_W{1'b0}};
      space_select_n <= 4'hf;
      read_strobe_n <= 1'b1;
      low_byte_write_strobe_n <= 1'b1;
      mem_dout <= 8'h0;
      mem_doe <= 1'b0;
   end else begin
      stall_sync_reg <= {stall_sync_reg[0], stall_n};
      din_s1_reg <= mem_din;
      done_pulse <= 1'b0;
      case (state_reg)
         `ST_IDLE: begin
            // idle counter saturates at the largest turnaround
            if (idle_cnt_reg != 2'h3)
               idle_cnt_reg <= idle_cnt_reg + 2'h1;
            if (req_valid && req_ready) begin
               cur_write_reg <= req_write;
               cur_space_reg <= req_space;
               cur_wait_reg <= field2(stall_count_control_reg, req_space, `SCC_WAIT_LSB);
               cur_ext_reg <= space_bit(bus_control_second_reg, req_space, `BCS_EXT_LSB);
               mem_addr <= req_addr;
               mem_dout <= req_wdata;
               mem_doe <= req_write;
               space_select_n <= ~(4'h1 << req_space);
               if (space_bit(bus_control_second_reg, req_space, `BCS_EXT_LSB)) begin
                  state_reg <= `ST_LEAD;
               end else begin
                  state_reg <= `ST_FIRST;
                  read_strobe_n <= req_write;
                  low_byte_write_strobe_n <= ~req_write;
               end
            end
         end
         `ST_LEAD: begin
            // select only; strobes fall on the way out
            state_reg <= `ST_FIRST;
            read_strobe_n <= cur_write_reg;
            low_byte_write_strobe_n <= ~cur_write_reg;
         end
         `ST_FIRST: begin
            wait_cnt_reg <= cur_wait_reg;
            state_reg <= (cur_wait_reg == 2'h0) ? `ST_SECOND : `ST_STALL;
         end
         `ST_STALL: begin
            // last wait holds while stall low; zero wait field never gets here
            if (wait_cnt_reg > 2'h1)
               wait_cnt_reg <= wait_cnt_reg - 2'h1;
            else if (!stall_low)
               state_reg <= `ST_SECOND;
         end
         `ST_SECOND: begin
            read_strobe_n <= 1'b1;
            low_byte_write_strobe_n <= 1'b1;
            if (!cur_write_reg) begin
               done_rdata <= din_s1_reg;
            end
            prev_space_reg <= cur_space_reg;
            prev_read_reg <= ~cur_write_reg;
            prev_valid_reg <= 1'b1;
            access_count_reg <= access_count_reg + 32'h1;
            if (cur_ext_reg) begin
               state_reg <= `ST_TRAIL;
            end else begin
               state_reg <= `ST_GAP;
               space_select_n <= 4'hf;
               mem_doe <= 1'b0;
               done_pulse <= 1'b1;
            end
         end
         `ST_TRAIL: begin
            // select and write data held one more cycle
            state_reg <= `ST_GAP;
            space_select_n <= 4'hf;
            mem_doe <= 1'b0;
            done_pulse <= 1'b1;
         end
         `ST_GAP: begin
            // gap itself counts as the first idle; the count is one on entering idle
            state_reg <= `ST_IDLE;
            idle_cnt_reg <= `IDLE_AFTER_GAP;
         end
         default: state_reg <= `ST_IDLE;
      endcase
   end
end
endmodule
`default_nettype wire

// ### testbench/bus_timing_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module bus_timing_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic req_ready,
   input wire logic done_pulse,
   input wire logic [3:0] space_select_n,
   input wire logic read_strobe_n,
   input wire logic low_byte_write_strobe_n,
   input wire logic mem_doe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   property p_rd; !read_strobe_n |-> $onehot(~space_select_n) && !mem_doe; endproperty
   a_rd: assert property (p_rd) else $error("read strobe without one select");
   property p_wr; !low_byte_write_strobe_n |-> $onehot(~space_select_n) && mem_doe && read_strobe_n; endproperty
   a_wr: assert property (p_wr) else $error("write strobe without select or data");
   property p_two_rd; $fell(read_strobe_n) |=> !read_strobe_n; endproperty
   a_two_rd: assert property (p_two_rd) else $error("read strobe too short");
   property p_two_wr; $fell(low_byte_write_strobe_n) |=> !low_byte_write_strobe_n; endproperty
   a_two_wr: assert property (p_two_wr) else $error("write strobe too short");
   property p_trail; $rose(low_byte_write_strobe_n) && space_select_n != 4'hf |-> mem_doe; endproperty
   a_trail: assert property (p_trail) else $error("write data dropped in trail");
   property p_gap; done_pulse |-> space_select_n == 4'hf && $past(space_select_n) != 4'hf; endproperty
   a_gap: assert property (p_gap) else $error("select not negated at access end");
   property p_ready; req_ready |-> space_select_n == 4'hf && read_strobe_n && low_byte_write_strobe_n; endproperty
   a_ready: assert property (p_ready) else $error("request taken mid access");
   property p_doe; mem_doe |-> space_select_n != 4'hf; endproperty
   a_doe: assert property (p_doe) else $error("data driven outside select");
   c_lead: cover property (space_select_n != 4'hf && read_strobe_n && low_byte_write_strobe_n);
   c_trail: cover property ($rose(read_strobe_n) && space_select_n != 4'hf);
   c_done: cover property (done_pulse ##1 req_ready);
endmodule
bind ordinary_space_bus_timing bus_timing_monitor i_mon (.*);
`default_nettype wire

// ### testbench/mem_partner.sv
`timescale 1ns/100ps
`default_nettype none
module mem_partner (
   input wire logic sys_clk,
   input wire logic read_strobe_n,
   input wire logic low_byte_write_strobe_n,
   input wire logic [7:0] mem_dout,
   input wire logic [15:0] rd_val,
   input wire logic [3:0] stall_len,
   output wire logic [15:0] mem_din,
   output wire logic stall_n,
   output logic [7:0] wr_byte
);
   logic [3:0] cnt = 4'h0;
   // inverse pattern once the strobe is gone
   assign mem_din = read_strobe_n ? ~rd_val : rd_val;
   assign stall_n = cnt == 4'h0;
   always @(posedge sys_clk) begin
      if (!low_byte_write_strobe_n)
         wr_byte <= mem_dout;
      if (read_strobe_n && low_byte_write_strobe_n)
         cnt <= stall_len;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
endmodule
`default_nettype wire

// ### testbench/ordinary_space_bus_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ordinary_space_bus_timing_tb;
   logic sys_clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0, req_write = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3, stall_len = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [1:0] req_space = 2'h0;
   logic [15:0] req_addr = 16'h0, rd_val = 16'h1234;
   logic [7:0] req_wdata = 8'h5a;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready, done_pulse;
   wire read_strobe_n, low_byte_write_strobe_n, mem_doe, stall_n;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] done_rdata, mem_addr, mem_din;
   wire [3:0] space_select_n;
   wire [7:0] mem_dout, wr_byte;
   int error_cnt = 0, compares = 0, sl, cl, wt;
   always #25 sys_clk = ~sys_clk;
   ordinary_space_bus_timing i_dut (.*);
   mem_partner i_mem (.*);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
      @(posedge sys_clk);
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rdata", s_axi_rdata, e);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
      @(posedge sys_clk);
   endtask
   task automatic cfg(input logic [15:0] b, input logic [15:0] w);
      axw(4'h4, {16'h0, b});
      axw(4'h0, {16'h0, w});
   endtask
   // idle counts cycles after the gap state; negative expectation skips
   task automatic acc(input logic w, input logic [1:0] s, input int pre, input int ei, input int es, input int ec);
      sl = 0; cl = 0; wt = 0;
      repeat (pre) @(posedge sys_clk);
      req_valid <= 1'h1; req_write <= w; req_space <= s; req_addr <= req_addr + 16'h1;
      req_wdata <= ~req_wdata; rd_val <= {rd_val[14:0], rd_val[15]} ^ 16'h0101;
      do begin
         @(posedge sys_clk);
         wt += (req_ready !== 1'h1);
      end while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      do begin
         @(posedge sys_clk);
         sl += (read_strobe_n === 1'h0 || low_byte_write_strobe_n === 1'h0);
         cl += (space_select_n !== 4'hf);
      end while (done_pulse !== 1'h1);
      if (ei >= 0) chk("idle", pre + 1 + wt, ei);
      if (es >= 0) chk("strobe", sl, es);
      if (ec >= 0) chk("select", cl, ec);
      if (w) chk("wbyte", {24'h0, wr_byte}, {24'h0, req_wdata});
      else chk("rdata", {16'h0, done_rdata}, {16'h0, rd_val});
      chk("addr", {16'h0, mem_addr}, {16'h0, req_addr});
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      axr(4'h0, 32'hffff, 2'h0);
      axr(4'h4, 32'hffff, 2'h0);
      axr(4'hc, 32'h0, 2'h2);
      acc(1'h0, 2'h0, 0, -1, 5, 7);
      acc(1'h1, 2'h1, 0, 3, 5, 7);
      axr(4'h8, 32'h2, 2'h0);
   endtask
   task automatic t_ext;
      cfg(16'h0000, 16'hcc00);
      acc(1'h0, 2'h0, 0, -1, 2, 2);
      acc(1'h1, 2'h1, 0, 1, 2, 2);
      cfg(16'h0008, 16'hcc00);
      acc(1'h0, 2'h3, 0, -1, 2, 4);
      acc(1'h1, 2'h3, 0, 1, 2, 4);
   endtask
   task automatic t_wait;
      for (int w = 1; w < 4; w++) begin
         cfg(16'h0, 16'hcc00 | (16'(w) << 8));
         acc(1'h0, 2'h2, 0, -1, 2 + w, 2 + w);
      end
      stall_len <= 4'h4;
      acc(1'h0, 2'h2, 0, -1, -1, -1);
      chk("stalled", {31'h0, sl > 5}, 32'h1);
      cfg(16'h0, 16'hcc00);
      acc(1'h0, 2'h2, 0, -1, 2, 2);
      stall_len <= 4'h0;
      axw(4'h0, 32'h0);
      axr(4'h0, 32'hcc00, 2'h0);
   endtask
   task automatic t_turn;
      for (int n = 0; n < 4; n++) begin
         cfg(16'(n) << 8, 16'hcc00);
         acc(1'h0, 2'h0, 0, -1, 2, 2);
         acc(1'h1, 2'h1, 0, n > 1 ? n : 1, 2, 2);
         acc(1'h0, 2'h0, 0, 1, 2, 2);
         acc(1'h0, 2'h0, 0, 1, 2, 2);
         acc(1'h0, 2'h1, 1, n > 2 ? n : 2, 2, 2);
      end
      cfg(16'h0210, 16'hcc00);
      acc(1'h0, 2'h0, 0, -1, 2, 2);
      acc(1'h1, 2'h0, 0, 2, 2, 2);
      acc(1'h1, 2'h0, 1, 2, 2, 2);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_reset;
      t_ext;
      t_wait;
      t_turn;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      stop_test;
   end
endmodule
`default_nettype wire
